/* logic/lbdc_pkg.sv */
package lbdc_pkg;
	localparam logic [7:0] OFF_LOCAL_BUS_CONFIG = 8'h40;
	localparam logic [7:0] OFF_CC_BLOCK_PTR = 8'h44;
	localparam logic [7:0] OFF_TRANSFER_START = 8'h4C;
	localparam logic [7:0] OFF_TX_IRQ_Q_BASE = 8'h50;
	localparam logic [7:0] OFF_TX_IRQ_Q_LEN = 8'h54;
	localparam logic [7:0] OFF_RX_IRQ_Q_BASE = 8'h58;
	localparam logic [7:0] OFF_RX_IRQ_Q_LEN = 8'h5C;
	localparam logic [7:0] OFF_MAP_A0 = 8'h60;
	localparam logic [7:0] OFF_MAP_A1 = 8'h64;
	localparam logic [7:0] OFF_MAP_B0 = 8'h68;
	localparam logic [7:0] OFF_MAP_B1 = 8'h6C;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h78;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h7C;
	localparam logic [7:0] OFF_CHAN_STATUS = 8'h80;
	// Own config register: validation code, pass-through, two block resets
	localparam int CFG_VAL_LSB = 0;
	localparam int CFG_PASS_BIT = 3;
	localparam int CFG_MMR_BIT = 4;
	localparam int CFG_EBR_BIT = 5;
	localparam logic [31:0] CFG_RESET = 32'h00000030;
	localparam logic [31:0] START_RESET = 32'h00000003;
	localparam logic [31:0] ALIGN_MASK = 32'hFFFFFFFC;
	localparam logic [31:0] LEN_MASK = 32'h000000FF;
	localparam logic [2:0] VAL_NONE = 3'h0;
	localparam logic [2:0] VAL_8 = 3'h5;
	localparam logic [2:0] VAL_16 = 3'h6;
	localparam logic [2:0] VAL_32 = 3'h7;
	localparam logic [5:0] PERIODS_8 = 6'h08;
	localparam logic [5:0] PERIODS_16 = 6'h10;
	localparam logic [5:0] PERIODS_32 = 6'h20;
	localparam int QUEUE_UNIT_DWORDS = 16;
	localparam int IRQ_BITS = 4;
	localparam int IRQ_END_A = 0;
	localparam int IRQ_END_B = 1;
	localparam int IRQ_PASS = 2;
	localparam int IRQ_FETCH = 3;
endpackage

/* logic/lbdc_req_filter.sv */
`timescale 1ns/1ps
module lbdc_req_filter
(
	input wire logic clk,
	input wire logic rst_n,
	lbdc_req_if.filter rq
);
	logic active_ff;
	logic [5:0] cnt_ff;
	logic end_ff;
	logic [5:0] nxt_cnt;
	always_comb
	begin
		nxt_cnt = cnt_ff;
		if (rq.req)
			nxt_cnt = 6'h00;
		else if (rq.clk_fall && active_ff && cnt_ff != rq.periods)
			nxt_cnt = cnt_ff + 6'h01;
	end
	// Request low only counts as idle after the hold-off elapses
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_ff <= 6'h00;
			active_ff <= 1'b0;
			end_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			end_ff <= 1'b0;
			if (rq.req && rq.clk_fall)
				active_ff <= 1'b1;
			// Fall that first sees the request low opens the hold-off; N more falls close it
			else if (active_ff && !rq.req && cnt_ff == rq.periods && rq.clk_fall)
			begin
				active_ff <= 1'b0;
				end_ff <= 1'b1;
			end
		end
	end
	assign rq.active = active_ff;
	assign rq.end_pulse = end_ff;
endmodule // lbdc_req_filter

/* logic/lbdc_req_if.sv */
`timescale 1ns/1ps
interface lbdc_req_if;
	logic clk_fall;
	logic [5:0] periods;
	logic req;
	logic active;
	logic end_pulse;
	modport owner (output clk_fall, output periods, output req, input active, input end_pulse);
	modport filter (input clk_fall, input periods, input req, output active, output end_pulse);
endinterface // lbdc_req_if

/* logic/lbdc_top.sv */
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module lbdc_top
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	input wire logic local_clock_output,
	input wire logic dma_request_chan_a,
	input wire logic dma_request_chan_b,
	input wire logic periph_irq,
	input wire logic periph_irq_from_status23,
	input wire logic tx_hold_a,
	input wire logic tx_hold_b,
	input wire logic desc_valid_a,
	input wire logic desc_valid_b,
	input wire logic tx_q_advance,
	input wire logic rx_q_advance,
	output logic fetch_desc_a,
	output logic fetch_desc_b,
	output logic req_active_a,
	output logic req_active_b,
	output logic end_of_packet_a,
	output logic end_of_packet_b,
	output logic mode_irq_take,
	output logic queue_irq_write,
	output logic mode_machine_reset_n,
	output logic ext_bus_ctrl_reset_n,
	output logic [31:0] cc_block_addr,
	output logic [31:0] tx_q_wr_addr,
	output logic [31:0] rx_q_wr_addr,
	output logic [31:0] chan_a_map0,
	output logic [31:0] chan_a_map1,
	output logic [31:0] chan_b_map0,
	output logic [31:0] chan_b_map1
);
	logic [31:0] cfg_ff;
	logic [31:0] ccb_ff;
	logic [1:0] start_ff;
	logic [31:0] txb_ff;
	logic [7:0] txl_ff;
	logic [31:0] rxb_ff;
	logic [7:0] rxl_ff;
	logic [31:0] mapa0_ff;
	logic [31:0] mapa1_ff;
	logic [31:0] mapb0_ff;
	logic [31:0] mapb1_ff;
	logic [lbdc_pkg::IRQ_BITS-1:0] sts_ff;
	logic [lbdc_pkg::IRQ_BITS-1:0] msk_ff;
	logic [2:0] lclk_sync_ff;
	logic [1:0] rqa_sync_ff;
	logic [1:0] rqb_sync_ff;
	logic [1:0] pirq_sync_ff;
	logic [1:0] p23_sync_ff;
	logic [11:0] txp_ff;
	logic [11:0] rxp_ff;
	logic fetch_a_ff;
	logic fetch_b_ff;
	logic mode_take_ff;
	logic queue_wr_ff;
	logic pirq_d_ff;
	logic [31:0] rdata_ff;
	logic [5:0] periods;
	logic lclk_fall;
	logic [lbdc_pkg::IRQ_BITS-1:0] events;
	logic [11:0] tx_last;
	logic [11:0] rx_last;
	logic pirq_rise;
	logic mm_run;
	lbdc_req_if rif_a ();
	lbdc_req_if rif_b ();

	// Pin inputs pass two flops; third stage of the clock only edge-detects
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			lclk_sync_ff <= 3'h0;
			rqa_sync_ff <= 2'h0;
			rqb_sync_ff <= 2'h0;
			pirq_sync_ff <= 2'h0;
			p23_sync_ff <= 2'h0;
		end
		else
		begin
			lclk_sync_ff <= {lclk_sync_ff[1:0], local_clock_output};
			rqa_sync_ff <= {rqa_sync_ff[0], dma_request_chan_a};
			rqb_sync_ff <= {rqb_sync_ff[0], dma_request_chan_b};
			pirq_sync_ff <= {pirq_sync_ff[0], periph_irq};
			p23_sync_ff <= {p23_sync_ff[0], periph_irq_from_status23};
		end
	end
	assign lclk_fall = lclk_sync_ff[2] && !lclk_sync_ff[1];

	always_comb
	begin
		unique case (cfg_ff[lbdc_pkg::CFG_VAL_LSB +: 3])
			lbdc_pkg::VAL_8: periods = lbdc_pkg::PERIODS_8;
			lbdc_pkg::VAL_16: periods = lbdc_pkg::PERIODS_16;
			lbdc_pkg::VAL_32: periods = lbdc_pkg::PERIODS_32;
			default: periods = 6'h00;
		endcase
	end

	assign rif_a.clk_fall = lclk_fall;
	assign rif_a.periods = periods;
	assign rif_a.req = rqa_sync_ff[1];
	assign rif_b.clk_fall = lclk_fall;
	assign rif_b.periods = periods;
	assign rif_b.req = rqb_sync_ff[1];
	lbdc_req_filter u_filt_a (.clk(clk), .rst_n(rst_n), .rq(rif_a));
	lbdc_req_filter u_filt_b (.clk(clk), .rst_n(rst_n), .rq(rif_b));
	assign req_active_a = rif_a.active;
	assign req_active_b = rif_b.active;
	assign end_of_packet_a = rif_a.end_pulse;
	assign end_of_packet_b = rif_b.end_pulse;

	// mode machine held while reset bit is low
	assign mm_run = cfg_ff[lbdc_pkg::CFG_MMR_BIT];
	assign mode_machine_reset_n = cfg_ff[lbdc_pkg::CFG_MMR_BIT];
	// bus controller held while reset bit is low
	assign ext_bus_ctrl_reset_n = cfg_ff[lbdc_pkg::CFG_EBR_BIT];

	assign pirq_rise = pirq_sync_ff[1] && !pirq_d_ff;
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pirq_d_ff <= 1'b0;
			mode_take_ff <= 1'b0;
			queue_wr_ff <= 1'b0;
			fetch_a_ff <= 1'b0;
			fetch_b_ff <= 1'b0;
		end
		else
		begin
			pirq_d_ff <= pirq_sync_ff[1];
			// pass status 2/3 interrupts to queue
			queue_wr_ff <= mm_run && pirq_rise && cfg_ff[lbdc_pkg::CFG_PASS_BIT]
				&& p23_sync_ff[1];
			mode_take_ff <= mm_run && pirq_rise
				&& !(cfg_ff[lbdc_pkg::CFG_PASS_BIT] && p23_sync_ff[1]);
			fetch_a_ff <= mm_run && !start_ff[0] && !tx_hold_a && desc_valid_a;
			fetch_b_ff <= mm_run && !start_ff[1] && !tx_hold_b && desc_valid_b;
		end
	end
	assign mode_irq_take = mode_take_ff;
	assign queue_irq_write = queue_wr_ff;
	assign fetch_desc_a = fetch_a_ff;
	assign fetch_desc_b = fetch_b_ff;

	assign tx_last = {txl_ff, 4'hF};
	assign rx_last = {rxl_ff, 4'hF};
	always_ff @(posedge clk)
	begin
		if (!rst_n || !mm_run)
		begin
			txp_ff <= 12'h000;
			rxp_ff <= 12'h000;
		end
		else
		begin
			if (tx_q_advance)
				txp_ff <= (txp_ff >= tx_last) ? 12'h000 : txp_ff + 12'h001;
			if (rx_q_advance)
				rxp_ff <= (rxp_ff >= rx_last) ? 12'h000 : rxp_ff + 12'h001;
		end
	end
	assign tx_q_wr_addr = txb_ff + {18'h00000, txp_ff, 2'h0};
	assign rx_q_wr_addr = rxb_ff + {18'h00000, rxp_ff, 2'h0};

	// Register writes
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cfg_ff <= lbdc_pkg::CFG_RESET;
			ccb_ff <= 32'h00000000;
			start_ff <= lbdc_pkg::START_RESET[1:0];
			txb_ff <= 32'h00000000;
			txl_ff <= 8'h00;
			rxb_ff <= 32'h00000000;
			rxl_ff <= 8'h00;
			mapa0_ff <= 32'h00000000;
			mapa1_ff <= 32'h00000000;
			mapb0_ff <= 32'h00000000;
			mapb1_ff <= 32'h00000000;
			msk_ff <= '0;
		end
		else if (reg_wr)
		begin
			unique case (reg_addr)
				lbdc_pkg::OFF_LOCAL_BUS_CONFIG: cfg_ff <= reg_wdata & 32'h0000003F;
				lbdc_pkg::OFF_CC_BLOCK_PTR: ccb_ff <= reg_wdata & lbdc_pkg::ALIGN_MASK;
				lbdc_pkg::OFF_TRANSFER_START: start_ff <= reg_wdata[1:0];
				lbdc_pkg::OFF_TX_IRQ_Q_BASE: txb_ff <= reg_wdata & lbdc_pkg::ALIGN_MASK;
				lbdc_pkg::OFF_TX_IRQ_Q_LEN: txl_ff <= reg_wdata[7:0];
				lbdc_pkg::OFF_RX_IRQ_Q_BASE: rxb_ff <= reg_wdata & lbdc_pkg::ALIGN_MASK;
				lbdc_pkg::OFF_RX_IRQ_Q_LEN: rxl_ff <= reg_wdata[7:0];
				lbdc_pkg::OFF_MAP_A0: mapa0_ff <= reg_wdata;
				lbdc_pkg::OFF_MAP_A1: mapa1_ff <= reg_wdata;
				lbdc_pkg::OFF_MAP_B0: mapb0_ff <= reg_wdata;
				lbdc_pkg::OFF_MAP_B1: mapb1_ff <= reg_wdata;
				lbdc_pkg::OFF_IRQ_MASK: msk_ff <= reg_wdata[lbdc_pkg::IRQ_BITS-1:0];
				default: ;
			endcase
		end
	end
	assign cc_block_addr = ccb_ff;
	assign chan_a_map0 = mapa0_ff;
	assign chan_a_map1 = mapa1_ff;
	assign chan_b_map0 = mapb0_ff;
	assign chan_b_map1 = mapb1_ff;

	// Sticky events; a new event beats the read-clear in the same cycle
	assign events = {fetch_a_ff | fetch_b_ff, queue_wr_ff,
		rif_b.end_pulse, rif_a.end_pulse};
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sts_ff <= '0;
		else if (reg_rd && reg_addr == lbdc_pkg::OFF_IRQ_STATUS)
			sts_ff <= events;
		else
			sts_ff <= sts_ff | events;
	end
	assign irq = |(sts_ff & msk_ff);

	// Read data valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rdata_ff <= 32'h00000000;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				lbdc_pkg::OFF_LOCAL_BUS_CONFIG: rdata_ff <= cfg_ff;
				lbdc_pkg::OFF_CC_BLOCK_PTR: rdata_ff <= ccb_ff;
				lbdc_pkg::OFF_TRANSFER_START: rdata_ff <= {30'h00000000, start_ff};
				lbdc_pkg::OFF_TX_IRQ_Q_BASE: rdata_ff <= txb_ff;
				lbdc_pkg::OFF_TX_IRQ_Q_LEN: rdata_ff <= {24'h000000, txl_ff};
				lbdc_pkg::OFF_RX_IRQ_Q_BASE: rdata_ff <= rxb_ff;
				lbdc_pkg::OFF_RX_IRQ_Q_LEN: rdata_ff <= {24'h000000, rxl_ff};
				lbdc_pkg::OFF_MAP_A0: rdata_ff <= mapa0_ff;
				lbdc_pkg::OFF_MAP_A1: rdata_ff <= mapa1_ff;
				lbdc_pkg::OFF_MAP_B0: rdata_ff <= mapb0_ff;
				lbdc_pkg::OFF_MAP_B1: rdata_ff <= mapb1_ff;
				lbdc_pkg::OFF_IRQ_STATUS: rdata_ff <= {28'h0000000, sts_ff};
				lbdc_pkg::OFF_IRQ_MASK: rdata_ff <= {28'h0000000, msk_ff};
				lbdc_pkg::OFF_CHAN_STATUS: rdata_ff <= {26'h0000000, rxp_ff == 12'h000,
					txp_ff == 12'h000, fetch_b_ff, fetch_a_ff, rif_b.active, rif_a.active};
				default: rdata_ff <= 32'h00000000;
			endcase
		end
		else
			rdata_ff <= 32'h00000000;
	end
	assign reg_rdata = rdata_ff;
endmodule // lbdc_top

/* sim/lbdc_monitor.sv */
`timescale 1ns/1ps
module lbdc_monitor
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic periph_irq,
	input wire logic periph_irq_from_status23,
	input wire logic tx_hold_a,
	input wire logic fetch_desc_a,
	input wire logic req_active_a,
	input wire logic end_of_packet_a,
	input wire logic mode_irq_take,
	input wire logic queue_irq_write,
	input wire logic mode_machine_reset_n,
	input wire logic [31:0] cc_block_addr
);
	logic [1:0] cfg_wr_ff;
	// Config writes reach the reset outputs one cycle later
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			cfg_wr_ff <= 2'h0;
		else
			cfg_wr_ff <= {cfg_wr_ff[0], reg_wr && reg_addr == 8'h40};
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_eop_pulse;
		end_of_packet_a |=> !end_of_packet_a;
	endproperty
	a_eop_pulse: assert property (p_eop_pulse) else $error("end pulse too long");
	property p_eop_drop;
		end_of_packet_a |-> ##[0:1] !req_active_a;
	endproperty
	a_eop_drop: assert property (p_eop_drop) else $error("still active at end");
	property p_fetch_hold;
		tx_hold_a |=> !fetch_desc_a;
	endproperty
	a_fetch_hold: assert property (p_fetch_hold) else $error("fetch under hold");
	property p_irq_mode;
		$rose(periph_irq) && !periph_irq_from_status23 && mode_machine_reset_n |->
			##[2:6] mode_irq_take;
	endproperty
	a_irq_mode: assert property (p_irq_mode) else $error("interrupt not taken");
	property p_irq_excl;
		queue_irq_write |-> !mode_irq_take;
	endproperty
	a_irq_excl: assert property (p_irq_excl) else $error("interrupt sent twice");
	property p_mode_off;
		!mode_machine_reset_n |-> !mode_irq_take && !queue_irq_write;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("machine busy in reset");
	property p_cc_write;
		$past(reg_wr) && $past(reg_addr) == 8'h44 |->
			cc_block_addr == ($past(reg_wdata) & 32'hFFFFFFFC);
	endproperty
	a_cc_write: assert property (p_cc_write) else $error("pointer write wrong");
	property p_mode_bit;
		cfg_wr_ff == 2'h0 |-> $stable(mode_machine_reset_n);
	endproperty
	a_mode_bit: assert property (p_mode_bit) else $error("reset bit moved alone");
	c_eop: cover property (end_of_packet_a);
	c_queue: cover property (queue_irq_write);
	c_fetch: cover property (fetch_desc_a);
endmodule // lbdc_monitor
bind lbdc_top lbdc_monitor lbdc_monitor_i (.*);

/* sim/lbdc_periph_model.sv */
`timescale 1ns/1ps
module lbdc_periph_model
(
	input wire logic clk,
	input wire logic req_a_on,
	input wire logic req_b_on,
	output logic local_clock_output,
	output logic dma_request_chan_a,
	output logic dma_request_chan_b
);
	logic [3:0] ph_ff = 4'h0;
	initial
	begin
		local_clock_output = 1'h1;
		dma_request_chan_a = 1'h0;
		dma_request_chan_b = 1'h0;
	end
	// Clock out runs free; requests move only at its falling edge
	always @(posedge clk)
	begin
		ph_ff <= ph_ff + 4'h1;
		local_clock_output <= !ph_ff[3];
		if (ph_ff == 4'h8)
		begin
			dma_request_chan_a <= req_a_on;
			dma_request_chan_b <= req_b_on;
		end
	end
endmodule // lbdc_periph_model

/* sim/local_bus_dma_config_bench.sv */
`timescale 1ns/1ps
module local_bus_dma_config_bench;
	logic clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, periph_irq = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, cc_block_addr, tx_q_wr_addr, rx_q_wr_addr;
	logic [31:0] chan_a_map0, chan_a_map1, chan_b_map0, chan_b_map1;
	logic periph_irq_from_status23 = 1'h0, tx_hold_a = 1'h0, tx_hold_b = 1'h0;
	logic desc_valid_a = 1'h1, desc_valid_b = 1'h1, tx_q_advance = 1'h0, rx_q_advance = 1'h0;
	logic req_a_on = 1'h0, req_b_on = 1'h0, local_clock_output;
	logic dma_request_chan_a, dma_request_chan_b, irq, fetch_desc_a, fetch_desc_b;
	logic req_active_a, req_active_b, end_of_packet_a, end_of_packet_b, mode_irq_take;
	logic queue_irq_write, mode_machine_reset_n, ext_bus_ctrl_reset_n;
	int num_errors = 0, checks_done = 0;
	lbdc_top lbdc_top_i (.*);
	lbdc_periph_model lbdc_periph_model_i (.*);
	always #2.5 clk = ~clk;
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want)
		begin
			num_errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] want, m = 32'hFFFFFFFF);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 check(reg_rdata & m, want);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// change with both resets low, then release them
	task automatic cfg(input logic [3:0] v);
		wr(8'h40, {28'h0, v});
		wr(8'h40, {26'h0, 2'h3, v});
	endtask
	task t_regs;
		logic [7:0] a;
		logic [31:0] m;
		for (int i = 0; i < 10; i++)
		begin
			a = (i == 0) ? 8'h44 : 8'h48 + 8'(4 * i);
			m = (a == 8'h4C) ? 32'h3 : (a == 8'h54 || a == 8'h5C) ? 32'hFF :
				(a >= 8'h60) ? 32'hFFFFFFFF : 32'hFFFFFFFC;
			rd(a, (a == 8'h4C) ? 32'h3 : 32'h0);
			wr(a, 32'hFFFFFFFF);
			rd(a, m);
		end
		rd(8'h90, 32'h0);
		check(chan_a_map1 & chan_b_map0, 32'hFFFFFFFF);
		check(chan_a_map0 & chan_b_map1, 32'hFFFFFFFF);
		check(cc_block_addr, 32'hFFFFFFFC);
	endtask
	task t_fetch;
		wr(8'h4C, 32'h0);
		tick(3);
		check(32'({fetch_desc_a, fetch_desc_b}), 32'h3);
		@(posedge clk);
		tx_hold_a <= 1'h1;
		tick(3);
		check(32'({fetch_desc_a, fetch_desc_b}), 32'h1);
		@(posedge clk);
		tx_hold_a <= 1'h0;
		wr(8'h4C, 32'h2);
		tick(3);
		check(32'({fetch_desc_a, fetch_desc_b}), 32'h2);
	endtask
	// Counts clock-out falls from request release to the end pulse
	task automatic pkt(output int n);
		int k;
		logic prev;
		n = 0;
		@(posedge clk);
		req_a_on <= 1'h1;
		req_b_on <= 1'h1;
		for (k = 0; k < 100 && req_active_a !== 1'h1; k++) tick(1);
		check(32'(req_active_b), 32'h1);
		@(posedge clk);
		req_a_on <= 1'h0;
		req_b_on <= 1'h0;
		for (k = 0; k < 100 && dma_request_chan_a !== 1'h0; k++) tick(1);
		prev = local_clock_output;
		for (k = 0; k < 1000 && end_of_packet_a !== 1'h1; k++)
		begin
			tick(1);
			n += int'(prev && !local_clock_output);
			prev = local_clock_output;
		end
		check(32'({end_of_packet_a, end_of_packet_b}), 32'h3);
	endtask
	task t_valid;
		int c[5];
		logic [2:0] code[5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
		wr(8'h7C, 32'h1);
		rd(8'h78, 32'h0, 32'h0);
		for (int i = 0; i < 5; i++)
		begin
			cfg({1'h0, code[i]});
			pkt(c[i]);
		end
		tick(2);
		check(c[1], c[0]);
		check(c[2] - c[0], 32'h8);
		check(c[3] - c[0], 32'h10);
		check(c[4] - c[0], 32'h20);
		check(32'(irq), 32'h1);
		rd(8'h78, 32'h3, 32'h3);
		check(32'(irq), 32'h0);
	endtask
	task automatic irq_one(input logic s, input logic [1:0] want);
		logic [1:0] got;
		got = 2'h0;
		@(posedge clk);
		periph_irq_from_status23 <= s;
		periph_irq <= 1'h1;
		repeat (8)
		begin
			tick(1);
			got |= {mode_irq_take, queue_irq_write};
		end
		@(posedge clk);
		periph_irq <= 1'h0;
		tick(8);
		check(32'(got), 32'(want));
	endtask
	task t_irq;
		cfg(4'h0);
		irq_one(1'h1, 2'h2);
		cfg(4'h8);
		irq_one(1'h1, 2'h1);
		irq_one(1'h0, 2'h2);
		wr(8'h40, 32'h28);
		tick(2);
		check(32'({mode_machine_reset_n, ext_bus_ctrl_reset_n}), 32'h1);
		irq_one(1'h1, 2'h0);
		wr(8'h40, 32'h18);
		tick(2);
		check(32'({mode_machine_reset_n, ext_bus_ctrl_reset_n}), 32'h2);
		cfg(4'h0);
	endtask
	task t_queue;
		wr(8'h50, 32'h1000);
		wr(8'h54, 32'h0);
		wr(8'h58, 32'h2000);
		wr(8'h5C, 32'h1);
		@(posedge clk);
		tx_q_advance <= 1'h1;
		rx_q_advance <= 1'h1;
		repeat (15) @(posedge clk);
		tx_q_advance <= 1'h0;
		#1 check(tx_q_wr_addr, 32'h103C);
		repeat (16) @(posedge clk);
		rx_q_advance <= 1'h0;
		#1 check(rx_q_wr_addr, 32'h207C);
		@(posedge clk);
		tx_q_advance <= 1'h1;
		rx_q_advance <= 1'h1;
		@(posedge clk);
		tx_q_advance <= 1'h0;
		rx_q_advance <= 1'h0;
		#1 check(tx_q_wr_addr ^ rx_q_wr_addr, 32'h3000);
		check(tx_q_wr_addr, 32'h1000);
	endtask
	task test_done;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		t_regs;
		t_fetch;
		t_valid;
		t_irq;
		t_queue;
		test_done;
	end
	initial
	begin
		#200000;
		num_errors++;
		test_done;
	end
endmodule // local_bus_dma_config_bench
